// ===== rtl/vector_map_pkg.sv
// Constants, types and the vector table for the interrupt vector address map
package vector_map_pkg;

   // Program word address width (word addresses up to 0x1FFF)
   localparam int ADDR_W = 13;
   localparam int SRC_W = 5;
   localparam int SRC_COUNT = 26;

   // Reset vector and base of the application-side table
   localparam logic [ADDR_W-1:0] RESET_VECTOR = 13'h0000;
   localparam logic [ADDR_W-1:0] APP_BASE = 13'h0000;

   // Processor control register on the core I/O port
   localparam int IO_ADDR_W = 6;
   localparam logic [IO_ADDR_W-1:0] CTRL_IO_ADDR = 6'h35;
   localparam int CTRL_VSEL_BIT = 1;
   localparam logic CTRL_VSEL_RESET = 1'h0;

   // Boot reset fuse: 1 means unprogrammed, 0 means programmed
   localparam logic FUSE_PROGRAMMED = 1'h0;

   // Edges the strap needs through its synchroniser before it is caught
   localparam logic [1:0] SYNC_WAIT = 2'h2;

   // Each slot is two program words wide
   localparam int SLOT_SHIFT = 1;

   // Source numbers, zero based, in table order
   localparam logic [SRC_W-1:0] SRC_RESET = 5'h00;
   localparam logic [SRC_W-1:0] SRC_LAST = 5'h19;

   // Base-table offsets of every slot
   localparam logic [ADDR_W-1:0] VEC_TABLE [SRC_COUNT] = '{
      13'h0000,
      13'h0002,
      13'h0004,
      13'h0006,
      13'h0008,
      13'h000A,
      13'h000C,
      13'h000E,
      13'h0010,
      13'h0012,
      13'h0014,
      13'h0016,
      13'h0018,
      13'h001A,
      13'h001C,
      13'h001E,
      13'h0020,
      13'h0022,
      13'h0024,
      13'h0026,
      13'h0028,
      13'h002A,
      13'h002C,
      13'h002E,
      13'h0030,
      13'h0032
   };

   typedef enum logic [3:0] {
      ST_SYNC = 4'h1,
      ST_IDLE = 4'h2,
      ST_LOOKUP = 4'h4,
      ST_ANSWER = 4'h8
   } map_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] offset;
      logic bad;
   } rom_state_t;

endpackage : vector_map_pkg

// ===== rtl/vector_offset_rom.sv
// Registered lookup of the base-table offset of one vector slot
module vector_offset_rom (
   input logic clk,
   input logic reset,
   input logic [vector_map_pkg::SRC_W-1:0] rd_index,
   output logic [vector_map_pkg::ADDR_W-1:0] rd_offset_r,
   output logic rd_bad_r
);

   vector_map_pkg::rom_state_t cur_r;
   vector_map_pkg::rom_state_t cur_nxt;

   // Slot offset equals twice the source number
   function automatic logic [vector_map_pkg::ADDR_W-1:0] slot_offset(
      input logic [vector_map_pkg::SRC_W-1:0] idx);
      logic [vector_map_pkg::ADDR_W-1:0] wide;
      wide = {{(vector_map_pkg::ADDR_W-vector_map_pkg::SRC_W){1'b0}}, idx};
      slot_offset = wide << vector_map_pkg::SLOT_SHIFT;
   endfunction

   always_comb begin
      cur_nxt = cur_r;
      if (reset) begin
         cur_nxt = '0;
      end else if (rd_index > vector_map_pkg::SRC_LAST) begin
         // Unknown source: answer with the reset slot and flag it
         cur_nxt.offset = vector_map_pkg::RESET_VECTOR;
         cur_nxt.bad = 1'b1;
      end else begin
         cur_nxt.offset = vector_map_pkg::VEC_TABLE[rd_index];
         cur_nxt.bad = (vector_map_pkg::VEC_TABLE[rd_index] != slot_offset(rd_index));
      end
   end

   always_ff @(posedge clk) begin
      cur_r <= cur_nxt;
   end

   assign rd_offset_r = cur_r.offset;
   assign rd_bad_r = cur_r.bad;

endmodule // vector_offset_rom

// ===== rtl/interrupt_vector_address_map.sv
// Reset and interrupt vector address generator for the core fetch logic
module interrupt_vector_address_map (
   input logic clk,
   input logic reset,
   input logic boot_reset_fuse_n,
   input logic [vector_map_pkg::ADDR_W-1:0] boot_start_addr,
   input logic io_write,
   input logic io_read,
   input logic [vector_map_pkg::IO_ADDR_W-1:0] io_addr,
   input logic [7:0] io_wdata,
   output logic [7:0] io_rdata_r,
   input logic take_valid,
   input logic [vector_map_pkg::SRC_W-1:0] take_source,
   output logic take_ready,
   output logic vector_valid_r,
   output logic [vector_map_pkg::ADDR_W-1:0] vector_addr_r,
   output logic [vector_map_pkg::SRC_W-1:0] vector_source_r,
   output logic vector_bad_r,
   output logic reset_vec_valid_r,
   output logic [vector_map_pkg::ADDR_W-1:0] reset_addr_r,
   output logic boot_reset_active_r,
   output logic vector_table_select_r,
   output logic [vector_map_pkg::ADDR_W-1:0] table_base_r
);

   typedef struct packed {
      vector_map_pkg::map_state_t state;
      logic [1:0] sync_cnt;
      logic fuse_meta;
      logic fuse_sync;
      logic fuse_programmed;
      logic vsel;
      logic [vector_map_pkg::ADDR_W-1:0] reset_addr;
      logic reset_valid;
      logic [vector_map_pkg::ADDR_W-1:0] table_base;
      logic [vector_map_pkg::ADDR_W-1:0] vec_addr;
      logic vec_valid;
      logic vec_bad;
      logic [vector_map_pkg::SRC_W-1:0] src;
      logic [7:0] io_rdata;
   } map_regs_t;

   map_regs_t cur_r;
   map_regs_t cur_nxt;

   logic [vector_map_pkg::ADDR_W-1:0] rom_offset;
   logic rom_bad;
   logic accept;
   logic ctrl_hit_wr;
   logic ctrl_hit_rd;

   // Word address of a slot above a chosen base, wrapping inside program space
   function automatic logic [vector_map_pkg::ADDR_W-1:0] add_base(
      input logic [vector_map_pkg::ADDR_W-1:0] base,
      input logic [vector_map_pkg::ADDR_W-1:0] offset);
      add_base = base + offset;
   endfunction

   // Base picked by a select, zero side or boot side
   function automatic logic [vector_map_pkg::ADDR_W-1:0] pick_base(
      input logic use_boot,
      input logic [vector_map_pkg::ADDR_W-1:0] boot_base);
      pick_base = use_boot ? boot_base : vector_map_pkg::APP_BASE;
   endfunction

   // Decode of the control register on the core I/O port
   function automatic logic ctrl_selected(
      input logic strobe,
      input logic [vector_map_pkg::IO_ADDR_W-1:0] addr);
      ctrl_selected = strobe && (addr == vector_map_pkg::CTRL_IO_ADDR);
   endfunction

   assign accept = take_valid && (cur_r.state == vector_map_pkg::ST_IDLE);
   assign take_ready = (cur_r.state == vector_map_pkg::ST_IDLE);
   assign ctrl_hit_wr = ctrl_selected(io_write, io_addr);
   assign ctrl_hit_rd = ctrl_selected(io_read, io_addr);

   // The lookup is addressed straight from the request so that data are ready one edge later
   vector_offset_rom u_rom (
      .clk(clk),
      .reset(reset),
      .rd_index(take_source),
      .rd_offset_r(rom_offset),
      .rd_bad_r(rom_bad)
   );

   always_comb begin
      cur_nxt = cur_r;

      // Strap passes two flip-flops before anything reads it
      cur_nxt.fuse_meta = boot_reset_fuse_n;
      cur_nxt.fuse_sync = cur_r.fuse_meta;

      // One-cycle pulses fall back unless set again below
      cur_nxt.reset_valid = 1'b0;
      cur_nxt.vec_valid = 1'b0;

      // Control register port; every bit other than the select bit reads as zero
      if (ctrl_hit_wr) begin
         cur_nxt.vsel = io_wdata[vector_map_pkg::CTRL_VSEL_BIT];
      end
      if (io_read) begin
         cur_nxt.io_rdata = '0;
         if (ctrl_hit_rd) begin
            cur_nxt.io_rdata[vector_map_pkg::CTRL_VSEL_BIT] = cur_r.vsel;
         end
      end

      // Current interrupt table start follows the select bit on its own
      cur_nxt.table_base = pick_base(cur_nxt.vsel, boot_start_addr);

      case (cur_r.state)
         vector_map_pkg::ST_SYNC: begin
            if (cur_r.sync_cnt == vector_map_pkg::SYNC_WAIT) begin
               // Fuse caught once after release; a programmed fuse reads as zero
               cur_nxt.fuse_programmed = (cur_r.fuse_sync == vector_map_pkg::FUSE_PROGRAMMED);
               // All reset kinds share this one start address
               cur_nxt.reset_addr = add_base(
                  pick_base(cur_nxt.fuse_programmed, boot_start_addr),
                  vector_map_pkg::VEC_TABLE[vector_map_pkg::SRC_RESET]);
               cur_nxt.reset_valid = 1'b1;
               cur_nxt.state = vector_map_pkg::ST_IDLE;
            end else begin
               cur_nxt.sync_cnt = cur_r.sync_cnt + 2'h1;
            end
         end
         vector_map_pkg::ST_IDLE: begin
            // Addresses are produced only when an interrupt is taken; fetches elsewhere are untouched
            if (accept) begin
               cur_nxt.src = take_source;
               cur_nxt.state = vector_map_pkg::ST_LOOKUP;
            end
         end
         vector_map_pkg::ST_LOOKUP: begin
            // Select bit as it stands at this edge decides the table
            cur_nxt.vec_addr = add_base(pick_base(cur_r.vsel, boot_start_addr), rom_offset);
            cur_nxt.vec_bad = rom_bad;
            cur_nxt.vec_valid = 1'b1;
            cur_nxt.state = vector_map_pkg::ST_ANSWER;
         end
         vector_map_pkg::ST_ANSWER: begin
            cur_nxt.state = vector_map_pkg::ST_IDLE;
         end
         default: begin
            cur_nxt.state = vector_map_pkg::ST_IDLE;
         end
      endcase

      if (reset) begin
         cur_nxt = '0;
         cur_nxt.state = vector_map_pkg::ST_SYNC;
         cur_nxt.vsel = vector_map_pkg::CTRL_VSEL_RESET;
         cur_nxt.reset_addr = vector_map_pkg::RESET_VECTOR;
         cur_nxt.table_base = vector_map_pkg::APP_BASE;
      end
   end

   always_ff @(posedge clk) begin
      cur_r <= cur_nxt;
   end

   assign io_rdata_r = cur_r.io_rdata;
   assign vector_valid_r = cur_r.vec_valid;
   assign vector_addr_r = cur_r.vec_addr;
   assign vector_source_r = cur_r.src;
   assign vector_bad_r = cur_r.vec_bad;
   assign reset_vec_valid_r = cur_r.reset_valid;
   assign reset_addr_r = cur_r.reset_addr;
   assign boot_reset_active_r = cur_r.fuse_programmed;
   assign vector_table_select_r = cur_r.vsel;
   assign table_base_r = cur_r.table_base;

endmodule // interrupt_vector_address_map

// ===== testbench/vector_map_chk.sv
// Port checks for the vector address map
module vector_map_chk (
   input logic clk,
   input logic reset,
   input logic boot_reset_fuse_n,
   input logic [12:0] boot_start_addr,
   input logic io_write,
   input logic io_read,
   input logic [5:0] io_addr,
   input logic [7:0] io_wdata,
   input logic [7:0] io_rdata_r,
   input logic take_valid,
   input logic [4:0] take_source,
   input logic take_ready,
   input logic vector_valid_r,
   input logic [12:0] vector_addr_r,
   input logic [4:0] vector_source_r,
   input logic vector_bad_r,
   input logic reset_vec_valid_r,
   input logic [12:0] reset_addr_r,
   input logic boot_reset_active_r,
   input logic vector_table_select_r,
   input logic [12:0] table_base_r
);
   timeunit 1ns;
   timeprecision 100ps;
   wire acc = take_valid && take_ready;
   wire ctl = io_addr == vector_map_pkg::CTRL_IO_ADDR;
   wire wsel = io_wdata[1];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_answer;
      !vector_valid_r ##1 vector_valid_r ##1 !vector_valid_r;
   endsequence
   sequence s_busy;
      !take_ready ##1 !take_ready ##1 take_ready;
   endsequence
   // Three quiet edges while the strap settles, then a one-cycle pulse
   sequence s_reset_pulse;
      !reset_vec_valid_r [*3] ##1 reset_vec_valid_r ##1 !reset_vec_valid_r;
   endsequence
   answer_timing_a: assert property (acc |=> s_answer)
      else $error("answer timing");
   take_spacing_a: assert property (acc |=> s_busy)
      else $error("take spacing");
   vector_addr_a: assert property (vector_valid_r && !vector_bad_r |-> vector_addr_r ==
      ($past(vector_table_select_r) ? $past(boot_start_addr) : 13'h0000) + {7'h00, vector_source_r, 1'b0})
      else $error("vector address");
   bad_flag_a: assert property (vector_valid_r |-> vector_bad_r == (vector_source_r > 5'h19))
      else $error("bad flag");
   reset_pulse_a: assert property ($fell(reset) |-> s_reset_pulse)
      else $error("reset pulse");
   reset_addr_a: assert property (reset_vec_valid_r |->
      reset_addr_r == (boot_reset_active_r ? $past(boot_start_addr) : 13'h0000))
      else $error("reset address");
   select_write_a: assert property (io_write && ctl |=> vector_table_select_r == $past(wsel))
      else $error("select write");
   select_read_a: assert property (io_read && ctl |=> io_rdata_r == {6'h00, $past(vector_table_select_r), 1'b0})
      else $error("select read");
   fuse_capture_a: assert property (reset_vec_valid_r |-> boot_reset_active_r == !$past(boot_reset_fuse_n, 3))
      else $error("fuse capture");
   table_base_a: assert property (table_base_r ==
      (vector_table_select_r ? $past(boot_start_addr) : 13'h0000))
      else $error("table base");
   source_capture_a: assert property (acc |=> vector_source_r == $past(take_source))
      else $error("source capture");
   no_spurious_a: assert property (vector_valid_r |-> $past(acc, 2))
      else $error("spurious vector");
endmodule // vector_map_chk

bind interrupt_vector_address_map vector_map_chk u_chk (.clk(clk), .reset(reset),
   .boot_reset_fuse_n(boot_reset_fuse_n),
   .boot_start_addr(boot_start_addr), .io_write(io_write), .io_read(io_read), .io_addr(io_addr),
   .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .take_valid(take_valid), .take_source(take_source),
   .take_ready(take_ready),
   .vector_valid_r(vector_valid_r), .vector_addr_r(vector_addr_r), .vector_source_r(vector_source_r),
   .vector_bad_r(vector_bad_r), .reset_vec_valid_r(reset_vec_valid_r), .reset_addr_r(reset_addr_r),
   .boot_reset_active_r(boot_reset_active_r), .vector_table_select_r(vector_table_select_r),
   .table_base_r(table_base_r));

// ===== testbench/core_model.sv
// Core fetch side model: takes interrupts and collects vector addresses
module core_model (
   input logic clk,
   input logic take_ready,
   input logic vector_valid_r,
   input logic [12:0] vector_addr_r,
   output logic take_valid,
   output logic [4:0] take_source
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      take_valid = 1'b0;
      take_source = 5'h00;
   end
   task take(input logic [4:0] src, output logic [12:0] addr);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      take_valid = 1'b1;
      take_source = src;
      while (take_ready !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      take_valid = 1'b0;
      // Released source shows a changed value, never the old one
      take_source = ~src;
      @(posedge clk);
      #1;
      addr = (vector_valid_r === 1'b1) ? vector_addr_r : 'x;
   endtask
endmodule // core_model

// ===== testbench/tb_top.sv
// Self-checking bench for the vector address map
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset, fuse_n, io_write, io_read, take_valid, take_ready, vvalid, vbad, rvalid, bact, vsel;
   logic [12:0] boot, vaddr, raddr, tbase;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, io_rdata, rdata;
   logic [4:0] take_source;
   int fails = 0, n_tests = 0, cyc = 0;
   interrupt_vector_address_map DUT (.clk(clk), .reset(reset), .boot_reset_fuse_n(fuse_n),
      .boot_start_addr(boot), .io_write(io_write), .io_read(io_read), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_rdata_r(io_rdata), .take_valid(take_valid), .take_source(take_source),
      .take_ready(take_ready), .vector_valid_r(vvalid), .vector_addr_r(vaddr), .vector_source_r(),
      .vector_bad_r(vbad), .reset_vec_valid_r(rvalid), .reset_addr_r(raddr),
      .boot_reset_active_r(bact), .vector_table_select_r(vsel), .table_base_r(tbase));
   core_model u_core (.clk(clk), .take_ready(take_ready), .vector_valid_r(vvalid),
      .vector_addr_r(vaddr), .take_valid(take_valid), .take_source(take_source));
   task check(input logic [12:0] got, input logic [12:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task do_reset(input logic fuse, input logic [12:0] b);
      int n;
      n = 0;
      @(posedge clk);
      #1 reset = 1'b1;
      fuse_n = fuse;
      boot = b;
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      while (rvalid !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1 n++;
      end
      check(13'(n), 13'h0003);
      check(raddr, fuse ? 13'h0000 : b);
      check({12'h000, bact}, {12'h000, !fuse});
      check({12'h000, vsel}, 13'h0000);
   endtask
   task io_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 io_write = 1'b1;
      io_addr = a;
      io_wdata = d;
      @(posedge clk);
      #1 io_write = 1'b0;
      io_wdata = ~d;
   endtask
   task io_rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 io_read = 1'b1;
      io_addr = a;
      @(posedge clk);
      #1 io_read = 1'b0;
      d = io_rdata;
   endtask
   task sc_control;
      io_wr(6'h34, 8'h02);
      io_rd(6'h35, rdata);
      check({5'h00, rdata}, 13'h0000);
      io_rd(6'h34, rdata);
      check({5'h00, rdata}, 13'h0000);
      io_wr(6'h35, 8'hFF);
      io_rd(6'h35, rdata);
      check({5'h00, rdata}, 13'h0002);
   endtask
   task sc_sweep(input logic [12:0] base);
      logic [12:0] a;
      for (int s = 0; s < 26; s++) begin
         u_core.take(5'(s), a);
         check(a, base + 13'(2 * s));
      end
      u_core.take(5'h1A, a);
      check(a, base);
      check({12'h000, vbad}, 13'h0001);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      reset = 1'b1;
      fuse_n = 1'b1;
      boot = 13'h1C00;
      io_write = 1'b0;
      io_read = 1'b0;
      io_addr = 6'h00;
      io_wdata = 8'h00;
      do_reset(1'b1, 13'h1C00);
      sc_sweep(13'h0000);
      sc_control;
      sc_sweep(13'h1C00);
      do_reset(1'b0, 13'h0C00);
      sc_sweep(13'h0000);
      io_wr(6'h35, 8'h02);
      sc_sweep(13'h0C00);
      check(tbase, 13'h0C00);
      close_out;
   end
endmodule // tb_top
